/* lsq_defs.svh */
// Purpose: constants for the light strobe sequencer (offsets, fields, resets, timing)
// Assumes: 40 MHz clock; word-aligned Avalon-MM byte addresses
// Notes: offsets below are word indices; the byte address is four times the index
`ifndef LSQ_DEFS_SVH
`define LSQ_DEFS_SVH

`define LSQ_A_CTRL 6'h00
`define LSQ_A_STAT 6'h01
`define LSQ_A_SHAPE 6'h02
`define LSQ_A_CAMW 6'h03
`define LSQ_A_TICK 6'h04
`define LSQ_T_MAP 2'h1
`define LSQ_T_PER 2'h2

`define LSQ_F_TYPE 1:0
`define LSQ_F_EVT 3:2
`define LSQ_B_APPLY 4
`define LSQ_F_NSEQ 1:0
`define LSQ_F_NFRM 5:4
`define LSQ_F_NEXE 15:8
`define LSQ_F_MAP 3:0
`define LSQ_F_WID 31:16
`define LSQ_F_PER 15:0

`define LSQ_M_CTRL 32'h0000000F
`define LSQ_M_SHAPE 32'h0000FF33
`define LSQ_M_HALF 32'h0000FFFF
`define LSQ_M_MAP 32'hFFFF000F

`define LSQ_RST_CTRL 32'h00000000
`define LSQ_RST_SHAPE 32'h00000033
`define LSQ_RST_CAMW 32'h00000001
`define LSQ_CLK_NS 25
`define LSQ_TICK_NS 1000
`define LSQ_RST_TICK (`LSQ_TICK_NS / `LSQ_CLK_NS)

`endif

/* lsq_pkg.sv */
// Purpose: shared types of the light strobe sequencer
// Assumes: nothing beyond the constants header
// Notes: encodings match the control register fields
package lsq_pkg;
  typedef enum logic [1:0] {
    LSQ_ONE_SHOT = 2'h0,
    LSQ_CONT = 2'h1,
    LSQ_FREE = 2'h2
  } lsq_type_e;

  typedef enum logic [1:0] {
    LSQ_EV_SERIES = 2'h0,
    LSQ_EV_SEQ = 2'h1,
    LSQ_EV_FRAME = 2'h2
  } lsq_evt_e;

  typedef enum logic [1:0] {
    LSQ_S_IDLE = 2'b01,
    LSQ_S_RUN = 2'b10
  } lsq_state_e;
endpackage

/* lsq_trig_in.sv */
// Purpose: trigger input synchroniser and rising-edge detector
// Assumes: trigger polarity already resolved outside
// Notes: first stage feeds only the second stage
module lsq_trig_in (
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // raw trigger and results
  input wire logic trigger_in,
  output logic level,
  output logic rise
);
  logic sync_a;
  logic sync_b;
  logic prev;

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      sync_a <= 1'b0;
      sync_b <= 1'b0;
      prev <= 1'b0;
    end else begin
      sync_a <= trigger_in;
      sync_b <= sync_a;
      prev <= sync_b;
    end
  end

  // a held level gives one pulse only
  assign level = sync_b;
  assign rise = sync_b & ~prev;
endmodule

/* lsq_tick_div.sv */
// Purpose: divider making the one-cycle time-base tick for frame timing
// Assumes: div of zero behaves as one
// Notes: clear realigns the phase when a run starts or new settings are applied
module lsq_tick_div #(
  parameter int W = 16
) (
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // control and tick
  input wire logic clear,
  input wire logic [W-1:0] div,
  output logic tick
);
  logic [W-1:0] cnt;
  wire logic [W:0] cnt_inc = {1'b0, cnt} + {{W{1'b0}}, 1'b1};

  assign tick = ~clear & (cnt_inc >= {1'b0, div});

  always_ff @(posedge clock) begin
    if (!rst_n || clear || tick) begin
      cnt <= '0;
    end else begin
      cnt <= cnt_inc[W-1:0];
    end
  end
endmodule

/* lsq_sequencer.sv */
// Purpose: trigger-driven four-channel strobe sequencer with Avalon-MM registers
// Assumes: trigger_in synchronous-safe via lsq_trig_in; master holds requests
// Notes: every access answers with waitrequest low in its second cycle
//
// Chosen here: the Avalon-MM register port and the register offsets.
`include "lsq_defs.svh"

module lsq_sequencer import lsq_pkg::*; (
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // avalon-mm slave
  input wire logic [7:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  output logic [31:0] readdata,
  output logic waitrequest,
  // trigger source
  input wire logic trigger_in,
  // light channels and camera
  output logic light_channel_one,
  output logic light_channel_two,
  output logic light_channel_three,
  output logic light_channel_four,
  output logic camera_trigger
);
  localparam int NCH = 4;

  function automatic logic [31:0] be_merge(input logic [31:0] old_w,
                                           input logic [31:0] new_w,
                                           input logic [3:0] be);
    logic [31:0] res;
    res = old_w;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        res[b*8 +: 8] = new_w[b*8 +: 8];
      end
    end
    return res;
  endfunction

  // configuration
  logic [31:0] ctrl;
  logic [31:0] shape;
  logic [31:0] camw;
  logic [31:0] tick_div;
  logic [31:0] frm_map [16];
  logic [31:0] frm_per [16];

  // sequencer state
  lsq_state_e state;
  logic [1:0] seq;
  logic [1:0] frm;
  logic [7:0] exe;
  logic [15:0] cnt;
  logic fell;
  logic [NCH-1:0] lights;
  logic cam;
  logic trig_lvl;
  logic trig_rise;

  // bus
  logic ack;
  logic [31:0] rd_word;
  wire logic req = read | write;
  wire logic [5:0] widx = address[7:2];
  wire logic [3:0] tidx = widx[3:0];
  wire logic hit_map = widx[5:4] == `LSQ_T_MAP;
  wire logic hit_per = widx[5:4] == `LSQ_T_PER;
  wire logic wr_go = write & ack;
  wire logic wr_ctrl = wr_go & (widx == `LSQ_A_CTRL);
  wire logic apply = wr_ctrl & byteenable[0] & writedata[`LSQ_B_APPLY];
  wire logic [31:0] new_ctrl = be_merge(ctrl, writedata, byteenable) & `LSQ_M_CTRL;

  assign waitrequest = req & ~ack;

  // status word; reserved bits read as zero
  // live view only, so software polling may miss a short strobe
  wire logic [31:0] stat_word = {
    2'h0,
    trig_lvl,
    exe,
    4'h0,
    cam,
    lights,
    2'h0,
    frm,
    2'h0,
    seq,
    3'h0,
    state == LSQ_S_RUN
  };

  always_comb begin
    rd_word = 32'h00000000;
    if (hit_map) begin
      rd_word = frm_map[tidx];
    end else if (hit_per) begin
      rd_word = frm_per[tidx];
    end else begin
      unique case (widx)
        `LSQ_A_CTRL: rd_word = ctrl;
        `LSQ_A_STAT: rd_word = stat_word;
        `LSQ_A_SHAPE: rd_word = shape;
        `LSQ_A_CAMW: rd_word = camw;
        `LSQ_A_TICK: rd_word = tick_div;
        default: rd_word = 32'h00000000;
      endcase
    end
  end

  // one wait state so read data always comes from a flop
  // a master that drops read before waitrequest falls gets stale data
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      ack <= 1'b0;
      readdata <= 32'h00000000;
    end else begin
      ack <= req & ~ack;
      if (read & ~ack) begin
        readdata <= rd_word;
      end
    end
  end

  // register writes take effect at the edge where waitrequest is low
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      ctrl <= `LSQ_RST_CTRL;
      shape <= `LSQ_RST_SHAPE;
      camw <= `LSQ_RST_CAMW;
      tick_div <= 32'(`LSQ_RST_TICK);
      for (int i = 0; i < 16; i++) begin
        frm_map[i] <= 32'h00000000;
        frm_per[i] <= 32'h00000000;
      end
    end else if (wr_go) begin
      if (hit_map) begin
        frm_map[tidx] <= be_merge(frm_map[tidx], writedata, byteenable) & `LSQ_M_MAP;
      end else if (hit_per) begin
        frm_per[tidx] <= be_merge(frm_per[tidx], writedata, byteenable) & `LSQ_M_HALF;
      end else if (widx == `LSQ_A_CTRL) begin
        ctrl <= new_ctrl;
      end else if (widx == `LSQ_A_SHAPE) begin
        shape <= be_merge(shape, writedata, byteenable) & `LSQ_M_SHAPE;
      end else if (widx == `LSQ_A_CAMW) begin
        camw <= be_merge(camw, writedata, byteenable) & `LSQ_M_HALF;
      end else if (widx == `LSQ_A_TICK) begin
        tick_div <= be_merge(tick_div, writedata, byteenable) & `LSQ_M_HALF;
      end
    end
  end

  // trigger and time base
  logic tick;
  logic start;

  lsq_trig_in u_trig (
    .clock(clock),
    .rst_n(rst_n),
    .trigger_in(trigger_in),
    .level(trig_lvl),
    .rise(trig_rise)
  );

  lsq_tick_div #(.W(16)) u_tick (
    .clock(clock),
    .rst_n(rst_n),
    .clear(start | apply),
    .div(tick_div[`LSQ_F_PER]),
    .tick(tick)
  );

  // decode of the active settings
  wire lsq_type_e mode = lsq_type_e'(ctrl[`LSQ_F_TYPE]);
  wire lsq_evt_e evt_raw = lsq_evt_e'(ctrl[`LSQ_F_EVT]);
  // granularity applies only to one-shot; other modes run whole series
  wire lsq_evt_e evt = (mode == LSQ_ONE_SHOT) ? evt_raw : LSQ_EV_SERIES;
  wire logic [1:0] last_seq = shape[`LSQ_F_NSEQ];
  wire logic [1:0] last_frm = shape[`LSQ_F_NFRM];
  wire logic [7:0] last_exe = shape[`LSQ_F_NEXE];
  wire logic running = state == LSQ_S_RUN;

  // current frame settings
  wire logic [3:0] fidx = {seq, frm};
  wire logic [NCH-1:0] map = frm_map[fidx][`LSQ_F_MAP];
  wire logic [15:0] width = frm_map[fidx][`LSQ_F_WID];
  wire logic [15:0] period = frm_per[fidx][`LSQ_F_PER];
  wire logic [16:0] cnt_inc = {1'b0, cnt} + 17'h00001;
  // a zero period still lasts one tick
  wire logic frame_end = running & tick & (cnt_inc >= {1'b0, period});

  // position bookkeeping
  wire logic f_last = frm == last_frm;
  wire logic e_last = exe == last_exe;
  wire logic s_last = seq == last_seq;
  wire logic seq_done = f_last & e_last;
  wire logic rec_done = seq_done & s_last;
  wire logic [1:0] nxt_frm = f_last ? 2'h0 : 2'(frm + 2'h1);
  wire logic [7:0] nxt_exe = !f_last ? exe : (e_last ? 8'h00 : 8'(exe + 8'h01));
  wire logic [1:0] nxt_seq = !seq_done ? seq : (s_last ? 2'h0 : 2'(seq + 2'h1));

  // end-of-run decision at a frame boundary
  logic stop;
  always_comb begin
    stop = 1'b0;
    unique case (mode)
      LSQ_FREE: stop = 1'b0;
      LSQ_CONT: stop = rec_done & (fell | ~trig_lvl);
      default: begin
        unique case (evt)
          LSQ_EV_FRAME: stop = 1'b1;
          LSQ_EV_SEQ: stop = seq_done;
          default: stop = rec_done;
        endcase
      end
    endcase
  end

  // free-run needs no trigger; other modes wait for an edge
  assign start = (state == LSQ_S_IDLE) & ~apply &
                 ((mode == LSQ_FREE) | trig_rise);

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      state <= LSQ_S_IDLE;
      seq <= 2'h0;
      frm <= 2'h0;
      exe <= 8'h00;
      cnt <= 16'h0000;
      fell <= 1'b0;
    end else if (apply) begin
      // new settings abort a run and rewind the recipe
      state <= LSQ_S_IDLE;
      seq <= 2'h0;
      frm <= 2'h0;
      exe <= 8'h00;
      cnt <= 16'h0000;
      fell <= 1'b0;
    end else begin
      unique case (state)
        LSQ_S_IDLE: begin
          if (start) begin
            state <= LSQ_S_RUN;
            cnt <= 16'h0000;
            fell <= 1'b0;
          end
        end
        LSQ_S_RUN: begin
          if (!trig_lvl) begin
            fell <= 1'b1;
          end
          if (frame_end) begin
            cnt <= 16'h0000;
            frm <= nxt_frm;
            exe <= nxt_exe;
            seq <= nxt_seq;
            if (stop) begin
              state <= LSQ_S_IDLE;
            end else if (rec_done) begin
              fell <= 1'b0;
            end
          end else if (tick) begin
            cnt <= 16'(cnt_inc);
          end
        end
        default: state <= LSQ_S_IDLE;
      endcase
    end
  end

  // output drive; all low whenever not inside a frame
  // registered so the light drivers never see decode glitches
  logic [NCH-1:0] next_lights;
  genvar c;
  generate
    for (c = 0; c < NCH; c++) begin : g_ch
      assign next_lights[c] = running & ~apply & map[c] & (cnt < width);
    end
  endgenerate
  wire logic next_cam = running & ~apply & (cnt < camw[`LSQ_F_PER]);

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      lights <= '0;
      cam <= 1'b0;
    end else begin
      lights <= next_lights;
      cam <= next_cam;
    end
  end

  assign light_channel_one = lights[0];
  assign light_channel_two = lights[1];
  assign light_channel_three = lights[2];
  assign light_channel_four = lights[3];
  assign camera_trigger = cam;
endmodule

/* lsq_seq_monitor.sv */
// Purpose: port checks of the light strobe sequencer
// Assumes: one clock, synchronous active-low reset
// Notes: sees only top-level ports
module lsq_seq_monitor (
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // bus
  input wire logic [7:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  input wire logic [31:0] readdata,
  input wire logic waitrequest,
  // outputs
  input wire logic light_channel_one,
  input wire logic light_channel_two,
  input wire logic light_channel_three,
  input wire logic light_channel_four,
  input wire logic camera_trigger
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  logic [3:0] lts;
  logic lit;
  assign lts = {light_channel_four, light_channel_three, light_channel_two, light_channel_one};
  assign lit = |lts;
  a_wait_idle: assert property (!(read || write) |-> !waitrequest)
    else $error("waitrequest with no request");
  a_wait_one: assert property ($rose(read || write) |-> waitrequest ##1 !waitrequest)
    else $error("request not answered in second cycle");
  a_unmapped_zero: assert property (read && !waitrequest && address == 8'h20 |-> readdata == 32'h0)
    else $error("unmapped read not zero");
  a_ctrl_reserved: assert property (read && !waitrequest && address == 8'h00
    |-> readdata[31:4] == 28'h0) else $error("control reserved bits set");
  a_dark_reset: assert property ($past(!rst_n) |-> !lit && !camera_trigger)
    else $error("outputs active after reset");
  a_light_cam: assert property ($rose(lit) |-> camera_trigger)
    else $error("strobe without camera trigger");
  a_status_lights: assert property (read && !waitrequest && address == 8'h04
    |-> readdata[15:12] == $past(lts)) else $error("status lights mismatch");
  a_apply_dark: assert property (write && !waitrequest && address == 8'h00 && byteenable[0]
    && writedata[4] && writedata[1:0] != 2'h2 |-> ##2 (!lit && !camera_trigger)[*4])
    else $error("outputs active after apply");
endmodule

/* lsq_far_model.sv */
// Purpose: trigger source, camera and light load model
// Assumes: trigger source gives clean sharp edges
// Notes: counts pulses and high cycles until cleared
module lsq_far_model (
  // clock
  input wire logic clock,
  // trigger source
  input wire logic trig_req,
  output logic trigger_in,
  // camera and lights
  input wire logic [3:0] lights,
  input wire logic camera_trigger,
  input wire logic clr,
  output logic [7:0] cam_pulses,
  output logic [7:0] cam_hi,
  output logic [3:0][7:0] lt_hi
);
  timeunit 1ns;
  timeprecision 100ps;
  logic cam_d;
  assign trigger_in = trig_req;
  always_ff @(posedge clock) begin
    cam_d <= camera_trigger;
    if (clr) begin
      cam_pulses <= 8'h00;
      cam_hi <= 8'h00;
      lt_hi <= 32'h0;
    end else begin
      if (camera_trigger && !cam_d) cam_pulses <= cam_pulses + 8'h01;
      if (camera_trigger) cam_hi <= cam_hi + 8'h01;
      for (int i = 0; i < 4; i++) if (lights[i]) lt_hi[i] <= lt_hi[i] + 8'h01;
    end
  end
endmodule

/* lsq_sequencer_tb.sv */
// Purpose: self-checking bench of the strobe sequencer
// Assumes: tick of one clock to keep runs short
// Notes: pulse and high-cycle counts come from the far model
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin err_total++; \
  $display("CHECK FAILED t=%0t got %0h exp %0h", $time, a, b); end end
module lsq_sequencer_tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic clock = 0, rst_n = 0, read = 0, write = 0, trig_req = 0, clr = 1, trigger_in;
  logic [7:0] address = 0;
  logic [31:0] writedata = 0, readdata, q;
  logic [3:0] byteenable = 0, lights;
  logic waitrequest, camera_trigger;
  logic [7:0] cam_pulses, cam_hi, v;
  logic [3:0][7:0] lt_hi;
  int err_total = 0, compares = 0, cyc = 0;
  lsq_sequencer u_dut (.clock(clock), .rst_n(rst_n), .address(address), .read(read),
    .write(write), .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
    .waitrequest(waitrequest), .trigger_in(trigger_in), .light_channel_one(lights[0]),
    .light_channel_two(lights[1]), .light_channel_three(lights[2]),
    .light_channel_four(lights[3]), .camera_trigger(camera_trigger));
  lsq_far_model u_far (.clock(clock), .trig_req(trig_req), .trigger_in(trigger_in),
    .lights(lights), .camera_trigger(camera_trigger), .clr(clr), .cam_pulses(cam_pulses),
    .cam_hi(cam_hi), .lt_hi(lt_hi));
  initial forever #12.5 clock = ~clock;
  // hang guard, well above the whole run
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_total++;
      end_of_test;
    end
  end
  task end_of_test;
    $display("errors %0d compares %0d", err_total, compares);
    if (err_total == 0 && compares > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    address <= a; writedata <= d; byteenable <= 4'hF; read <= !wr; write <= wr;
    do @(posedge clock); while (waitrequest !== 1'b0);
    q = readdata;
    read <= 1'b0;
    write <= 1'b0;
  endtask
  task rd_chk(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    `CHK(q, e)
  endtask
  task cfg(input logic [31:0] ctl, input logic [31:0] shp);
    bus(1'b1, 8'h10, 32'h1);
    bus(1'b1, 8'h08, shp);
    bus(1'b1, 8'h0C, 32'h2);
    bus(1'b1, 8'h40, 32'h0002_0001);
    bus(1'b1, 8'h80, 32'h4);
    bus(1'b1, 8'h44, 32'h0003_000C);
    bus(1'b1, 8'h84, 32'h5);
    bus(1'b1, 8'h00, ctl | 32'h10);
    @(posedge clock) clr <= 1'b1;
    @(posedge clock) clr <= 1'b0;
  endtask
  task pulse;
    @(posedge clock) trig_req <= 1'b1;
    repeat (5) @(posedge clock);
    trig_req <= 1'b0;
    repeat (30) @(posedge clock);
  endtask
  task t_reset;
    rd_chk(8'h00, 32'h0);
    rd_chk(8'h08, 32'h33);
    rd_chk(8'h0C, 32'h1);
    rd_chk(8'h10, 32'h28);
    bus(1'b1, 8'h04, 32'hFFFF_FFFF);
    rd_chk(8'h04, 32'h0);
    bus(1'b1, 8'h20, 32'hFFFF_FFFF);
    rd_chk(8'h20, 32'h0);
    $display("reset test done");
  endtask
  task t_oneshot;
    cfg(32'h0, 32'h10);
    repeat (20) @(posedge clock);
    `CHK(cam_pulses, 8'h00)
    @(posedge clock) trig_req <= 1'b1;
    repeat (60) @(posedge clock);
    `CHK(cam_pulses, 8'h02)
    `CHK(cam_hi, 8'h04)
    `CHK(lt_hi, {8'h03, 8'h03, 8'h00, 8'h02})
    repeat (40) @(posedge clock);
    `CHK(cam_pulses, 8'h02)
    trig_req <= 1'b0;
    $display("one-shot test done");
  endtask
  task t_frame;
    cfg(32'h08, 32'h10);
    pulse;
    `CHK(cam_pulses, 8'h01)
    `CHK(lt_hi, {8'h00, 8'h00, 8'h00, 8'h02})
    pulse;
    `CHK(lt_hi, {8'h03, 8'h03, 8'h00, 8'h02})
    pulse;
    `CHK(lt_hi[0], 8'h04)
    `CHK(cam_pulses, 8'h03)
    $display("frame test done");
  endtask
  task t_seq;
    cfg(32'h04, 32'h110);
    pulse;
    `CHK(cam_pulses, 8'h04)
    pulse;
    `CHK(lt_hi[0], 8'h08)
    $display("sequence test done");
  endtask
  task t_cont;
    cfg(32'h01, 32'h10);
    @(posedge clock) trig_req <= 1'b1;
    repeat (50) @(posedge clock);
    trig_req <= 1'b0;
    repeat (40) @(posedge clock);
    v = cam_pulses;
    `CHK(v[0], 1'b0)
    `CHK(v >= 8'h04, 1'b1)
    repeat (40) @(posedge clock);
    `CHK(cam_pulses, v)
    $display("continuous test done");
  endtask
  task t_free;
    cfg(32'h02, 32'h10);
    repeat (40) @(posedge clock);
    `CHK(cam_pulses != 8'h00, 1'b1)
    bus(1'b0, 8'h04, 32'h0);
    `CHK(q[0], 1'b1)
    cfg(32'h0, 32'h10);
    repeat (30) @(posedge clock);
    `CHK(cam_pulses, 8'h00)
    `CHK({lights, camera_trigger}, 5'h00)
    $display("free-run test done");
  endtask
  initial begin
    repeat (12) @(posedge clock);
    rst_n <= 1'b1;
    clr <= 1'b0;
    t_reset;
    t_oneshot;
    t_frame;
    t_seq;
    t_cont;
    t_free;
    end_of_test;
  end
endmodule
bind lsq_sequencer lsq_seq_monitor u_mon (.clock(clock), .rst_n(rst_n), .address(address),
  .read(read), .write(write), .writedata(writedata), .byteenable(byteenable),
  .readdata(readdata), .waitrequest(waitrequest), .light_channel_one(light_channel_one),
  .light_channel_two(light_channel_two), .light_channel_three(light_channel_three),
  .light_channel_four(light_channel_four), .camera_trigger(camera_trigger));
